// >>> pcs_link_map.svh
// Register indices, field positions, reset values and timing counts of the PCS link control block.
// Assumes a 50 MHz sys_clk; byte address of a register is four times its index.
`ifndef PCS_LINK_MAP_SVH
`define PCS_LINK_MAP_SVH

// ==========================================
// Register indices
`define IDX_LINK_CTRL 14'h0485
`define IDX_ERR_THR 14'h0486
`define IDX_SLEEP_EN 14'h0487
`define IDX_ILV_CFG 14'h0489
`define IDX_SLEEP_TMR 14'h0493
`define IDX_JABBER_TIMEOUT_CONFIG 14'h0496
`define IDX_TM_CFG 14'h0497
`define IDX_IRQ_STAT 14'h04c0
`define IDX_IRQ_MASK 14'h04c1
`define IDX_LINK_STAT 14'h04c2

// ==========================================
// Reset values and writable masks
`define RST_LINK_CTRL 16'h1078
`define RST_ERR_THR 16'h0a05
`define RST_SLEEP_EN 16'h0a00
`define RST_ILV_CFG 16'h0001
`define RST_SLEEP_TMR 16'h0014
`define RST_JABBER_TIMEOUT_CONFIG 16'h044c
`define RST_TM_CFG 16'h01c0
`define WM_LINK_CTRL 16'hf1ff
`define WM_ALL 16'hffff
`define WM_ILV_CFG 16'h0007
`define WM_JABBER_TIMEOUT_CONFIG 16'h07ff
`define WM_TM_CFG 16'h03ff

// ==========================================
// Field positions
`define LC_IPG_DIS_BIT 13
`define LC_LINK_EN_BIT 12
`define LC_IDLE_MSB 8
`define LC_IDLE_LSB 0
`define ET_LOCK_MSB 13
`define ET_LOCK_LSB 9
`define ET_RR_MSB 4
`define ET_RR_LSB 0
`define SE_EN_BIT 0
`define IC_FORCE_BIT 2
`define IC_EN_BIT 1
`define IC_DET_BIT 0
`define JC_TMO_MSB 10
`define JC_TMO_LSB 0
`define TC_SYM_MSB 9
`define TC_SYM_LSB 4

// ==========================================
// Interrupt events
`define IRQ_W 5
`define EV_LINK_UP 0
`define EV_LOCK_LOST 1
`define EV_REMOTE_LOW 2
`define EV_JABBER 3
`define EV_TM_DONE 4

// ==========================================
// Timing
`define CLK_NS 20
`define US_NS 1000
`define JAB_US_CYC (`US_NS / `CLK_NS)
`define TM_SYM_NS 15
`define TM_SYM_CYC ((`TM_SYM_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> pcs_link_pkg.sv
// Types of the PCS link control block: bus carriers, states and the state record.
// Assumes pcs_link_map.svh is on the include path.
`include "pcs_link_map.svh"
package pcs_link_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} apb_in_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_out_s;

	typedef struct packed {
		logic valid;
		logic idle;
		logic err;
		logic in_ipg;
	} rx_sym_s;

	typedef enum logic [2:0] {
		LINK_OFF = 3'b001,
		LINK_ACQ = 3'b010,
		LINK_UP = 3'b100
	} link_state_e;

	typedef enum logic [1:0] {
		TM_IDLE = 2'b01,
		TM_RUN = 2'b10
	} tm_state_e;

	typedef struct packed {
		logic [15:0] link_ctrl;
		logic [15:0] err_thr;
		logic [15:0] sleep_en;
		logic [15:0] ilv_cfg;
		logic [15:0] sleep_tmr;
		logic [15:0] jabber_timeout_config;
		logic [15:0] tm_cfg;
		logic [`IRQ_W-1:0] irq_stat;
		logic [`IRQ_W-1:0] irq_mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		link_state_e link_st;
		logic link_up;
		logic training_en;
		logic remote_ok;
		logic sleep_code_en;
		logic ilv_seen;
		logic tx_ilv;
		logic [5:0] us_div;
		logic [10:0] us_cnt;
		logic jabber;
		tm_state_e tm_st;
		logic [7:0] tm_left;
		logic [1:0] tm_div;
		logic tm_valid;
		logic tm_pos;
		logic irq;
	} pcs_state_s;

endpackage

// >>> threshold_counter.sv
// Saturating symbol counter with a registered threshold hit flag.
// Assumes clr and inc come from logic on the same clock.
`timescale 1ns/1ps
module threshold_counter #(
	parameter int W = 9
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic inc,
	input wire logic [W-1:0] limit,
	output logic hit
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic hit_r;
	logic hit_nxt;

	always_comb begin
		count_nxt = count_r;
		if (clr) begin
			count_nxt = '0;
		end else if (inc && count_r != {W{1'b1}}) begin
			count_nxt = count_r + 1'b1;
		end
		hit_nxt = !clr && (count_nxt >= limit);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
			hit_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			hit_r <= hit_nxt;
		end
	end

	assign hit = hit_r;
endmodule

// >>> pcs_link_control_regs.sv
// PCS link control register bank on APB with the lock, jabber, interleave and test-mode logic it steers.
// Assumes receive symbol flags, tx_active and tm1_start come from logic on sys_clk.
`timescale 1ns/1ps
`include "pcs_link_map.svh"
module pcs_link_control_regs (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire pcs_link_pkg::apb_in_s apb_in,
	output pcs_link_pkg::apb_out_s apb_out,
	input wire pcs_link_pkg::rx_sym_s rx_sym,
	input wire logic rx_ilv_seen,
	input wire logic tx_active,
	input wire logic tm1_start,
	output logic link_up,
	output logic training_en,
	output logic remote_rx_ok,
	output logic sleep_code_en,
	output logic tx_interleave,
	output logic jabber,
	output logic tm1_valid,
	output logic tm1_positive,
	output logic irq
);
	import pcs_link_pkg::*;

	pcs_state_s s_r;
	pcs_state_s s_nxt;
	logic [`IRQ_W-1:0] ev;
	logic [`IRQ_W-1:0] stat_clr;
	logic [13:0] sel_idx;
	logic setup;
	logic wr;
	logic ipg_dis;
	logic link_on;
	logic chk_err;
	logic idle_clr;
	logic idle_inc;
	logic err_clr;
	logic idle_hit;
	logic err_hit;
	logic rr_hit;

	// ==========================================
	// Symbol counters
	assign ipg_dis = s_r.link_ctrl[`LC_IPG_DIS_BIT];
	assign link_on = s_r.link_ctrl[`LC_LINK_EN_BIT];
	assign chk_err = rx_sym.valid & (rx_sym.err | (rx_sym.in_ipg & ~rx_sym.idle)) & ~(rx_sym.in_ipg & ipg_dis);
	assign idle_clr = (s_r.link_st != LINK_ACQ) | (rx_sym.valid & ~rx_sym.idle);
	assign idle_inc = rx_sym.valid & rx_sym.idle;
	assign err_clr = (s_r.link_st != LINK_UP);

	threshold_counter #(.W(9)) u_idle_cnt (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(idle_clr),
		.inc(idle_inc),
		.limit(s_r.link_ctrl[`LC_IDLE_MSB:`LC_IDLE_LSB]),
		.hit(idle_hit)
	);

	threshold_counter #(.W(6)) u_lock_err_cnt (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(err_clr),
		.inc(chk_err),
		.limit({s_r.err_thr[`ET_LOCK_MSB:`ET_LOCK_LSB], 1'b0}),
		.hit(err_hit)
	);

	threshold_counter #(.W(5)) u_remote_err_cnt (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(err_clr),
		.inc(chk_err),
		.limit(s_r.err_thr[`ET_RR_MSB:`ET_RR_LSB]),
		.hit(rr_hit)
	);

	// ==========================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		ev = '0;
		stat_clr = '0;
		sel_idx = apb_in.paddr[15:2];
		setup = apb_in.psel & ~apb_in.penable;
		wr = apb_in.psel & apb_in.penable & apb_in.pwrite & s_r.pready;

		// Read data captured in setup, zero-wait access
		s_nxt.pready = setup;
		if (setup) begin
			s_nxt.prdata = '0;
			s_nxt.pslverr = 1'b0;
			case (sel_idx)
				`IDX_LINK_CTRL: s_nxt.prdata = {16'h0000, s_r.link_ctrl};
				`IDX_ERR_THR: s_nxt.prdata = {16'h0000, s_r.err_thr};
				`IDX_SLEEP_EN: s_nxt.prdata = {16'h0000, s_r.sleep_en};
				`IDX_ILV_CFG: s_nxt.prdata = {16'h0000, s_r.ilv_cfg};
				`IDX_SLEEP_TMR: s_nxt.prdata = {16'h0000, s_r.sleep_tmr};
				`IDX_JABBER_TIMEOUT_CONFIG: s_nxt.prdata = {16'h0000, s_r.jabber_timeout_config};
				`IDX_TM_CFG: s_nxt.prdata = {16'h0000, s_r.tm_cfg};
				`IDX_IRQ_STAT: s_nxt.prdata = {27'h0000000, s_r.irq_stat};
				`IDX_IRQ_MASK: s_nxt.prdata = {27'h0000000, s_r.irq_mask};
				`IDX_LINK_STAT: s_nxt.prdata = {26'h0000000, s_r.jabber, s_r.tx_ilv, s_r.ilv_seen,
					s_r.remote_ok, s_r.link_up, s_r.training_en};
				default: s_nxt.pslverr = 1'b1;
			endcase
		end

		// Masked writes keep read-only reserved bits at their defaults
		if (wr) begin
			case (sel_idx)
				`IDX_LINK_CTRL: s_nxt.link_ctrl = (s_r.link_ctrl & ~`WM_LINK_CTRL) | (apb_in.pwdata[15:0] & `WM_LINK_CTRL);
				`IDX_ERR_THR: s_nxt.err_thr = apb_in.pwdata[15:0] & `WM_ALL;
				`IDX_SLEEP_EN: s_nxt.sleep_en = apb_in.pwdata[15:0] & `WM_ALL;
				`IDX_ILV_CFG: s_nxt.ilv_cfg = (s_r.ilv_cfg & ~`WM_ILV_CFG) | (apb_in.pwdata[15:0] & `WM_ILV_CFG);
				`IDX_SLEEP_TMR: s_nxt.sleep_tmr = apb_in.pwdata[15:0] & `WM_ALL;
				`IDX_JABBER_TIMEOUT_CONFIG: s_nxt.jabber_timeout_config = (s_r.jabber_timeout_config & ~`WM_JABBER_TIMEOUT_CONFIG) | (apb_in.pwdata[15:0] & `WM_JABBER_TIMEOUT_CONFIG);
				`IDX_TM_CFG: s_nxt.tm_cfg = (s_r.tm_cfg & ~`WM_TM_CFG) | (apb_in.pwdata[15:0] & `WM_TM_CFG);
				`IDX_IRQ_STAT: stat_clr = apb_in.pwdata[`IRQ_W-1:0];
				`IDX_IRQ_MASK: s_nxt.irq_mask = apb_in.pwdata[`IRQ_W-1:0];
				default: stat_clr = '0;
			endcase
		end

		// Link state
		case (s_r.link_st)
			LINK_OFF: begin
				if (link_on) begin
					s_nxt.link_st = LINK_ACQ;
				end
			end
			LINK_ACQ: begin
				if (!link_on) begin
					s_nxt.link_st = LINK_OFF;
				end else if (idle_hit) begin
					s_nxt.link_st = LINK_UP;
					ev[`EV_LINK_UP] = 1'b1;
				end
			end
			LINK_UP: begin
				if (!link_on) begin
					s_nxt.link_st = LINK_OFF;
				end else if (err_hit) begin
					s_nxt.link_st = LINK_ACQ;
					ev[`EV_LOCK_LOST] = 1'b1;
				end
			end
			default: s_nxt.link_st = LINK_OFF;
		endcase
		s_nxt.link_up = (s_nxt.link_st == LINK_UP);
		s_nxt.training_en = link_on;
		if (s_nxt.link_st != LINK_UP) begin
			s_nxt.remote_ok = 1'b0;
		end else if (s_r.link_st != LINK_UP) begin
			s_nxt.remote_ok = 1'b1;
		end else if (rr_hit && s_r.remote_ok) begin
			s_nxt.remote_ok = 1'b0;
			ev[`EV_REMOTE_LOW] = 1'b1;
		end

		s_nxt.sleep_code_en = s_r.sleep_en[`SE_EN_BIT];

		// Interleave selection
		if (!s_r.ilv_cfg[`IC_DET_BIT]) begin
			s_nxt.ilv_seen = 1'b0;
		end else if (rx_ilv_seen) begin
			s_nxt.ilv_seen = 1'b1;
		end
		s_nxt.tx_ilv = s_r.ilv_cfg[`IC_FORCE_BIT]
			| (s_r.ilv_cfg[`IC_EN_BIT] & s_r.ilv_cfg[`IC_DET_BIT] & s_nxt.ilv_seen);

		// Jabber timer in whole microseconds
		if (!tx_active) begin
			s_nxt.us_div = '0;
			s_nxt.us_cnt = '0;
			s_nxt.jabber = 1'b0;
		end else if (!s_r.jabber) begin
			if (s_r.us_cnt == s_r.jabber_timeout_config[`JC_TMO_MSB:`JC_TMO_LSB]) begin
				s_nxt.jabber = 1'b1;
				ev[`EV_JABBER] = 1'b1;
			end else if (s_r.us_div == 6'(`JAB_US_CYC - 1)) begin
				s_nxt.us_div = '0;
				s_nxt.us_cnt = s_r.us_cnt + 11'h001;
			end else begin
				s_nxt.us_div = s_r.us_div + 6'h01;
			end
		end

		// Test mode 1 symbol burst
		case (s_r.tm_st)
			TM_IDLE: begin
				if (tm1_start) begin
					s_nxt.tm_st = TM_RUN;
					s_nxt.tm_left = {1'b0, s_r.tm_cfg[`TC_SYM_MSB:`TC_SYM_LSB], 1'b0} + 8'h02;
					s_nxt.tm_div = '0;
					s_nxt.tm_valid = 1'b1;
					s_nxt.tm_pos = 1'b1;
				end
			end
			TM_RUN: begin
				if (s_r.tm_div == 2'(`TM_SYM_CYC - 1)) begin
					s_nxt.tm_div = '0;
					if (s_r.tm_left == 8'h01) begin
						s_nxt.tm_st = TM_IDLE;
						s_nxt.tm_valid = 1'b0;
						ev[`EV_TM_DONE] = 1'b1;
					end else begin
						s_nxt.tm_left = s_r.tm_left - 8'h01;
						s_nxt.tm_pos = ~s_r.tm_pos;
					end
				end else begin
					s_nxt.tm_div = s_r.tm_div + 2'h1;
				end
			end
			default: s_nxt.tm_st = TM_IDLE;
		endcase

		// Sticky status, set wins over clear
		s_nxt.irq_stat = (s_r.irq_stat & ~stat_clr) | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.link_ctrl <= `RST_LINK_CTRL;
			s_r.err_thr <= `RST_ERR_THR;
			s_r.sleep_en <= `RST_SLEEP_EN;
			s_r.ilv_cfg <= `RST_ILV_CFG;
			s_r.sleep_tmr <= `RST_SLEEP_TMR;
			s_r.jabber_timeout_config <= `RST_JABBER_TIMEOUT_CONFIG;
			s_r.tm_cfg <= `RST_TM_CFG;
			s_r.link_st <= LINK_OFF;
			s_r.tm_st <= TM_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_out = '{prdata: s_r.prdata, pready: s_r.pready, pslverr: s_r.pslverr};
	assign link_up = s_r.link_up;
	assign training_en = s_r.training_en;
	assign remote_rx_ok = s_r.remote_ok;
	assign sleep_code_en = s_r.sleep_code_en;
	assign tx_interleave = s_r.tx_ilv;
	assign jabber = s_r.jabber;
	assign tm1_valid = s_r.tm_valid;
	assign tm1_positive = s_r.tm_pos;
	assign irq = s_r.irq;

	// ==========================================
	// Checks
	logic [8:0] tm_seen_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tm_seen_r <= '0;
		end else if (s_r.tm_valid) begin
			tm_seen_r <= tm_seen_r + 9'h001;
		end else begin
			tm_seen_r <= '0;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_ipg_skip;
		rx_sym.in_ipg && ipg_dis |-> !chk_err;
	endproperty
	a_ipg_skip: assert property (p_ipg_skip) else $error("gap error counted while check disabled");

	property p_link_off;
		!link_on |=> !link_up && !training_en;
	endproperty
	a_link_off: assert property (p_link_off) else $error("link active while link control clear");

	property p_lock_needs_idles;
		$rose(link_up) |-> $past(idle_hit) && $past(s_r.link_st) == LINK_ACQ;
	endproperty
	a_lock_needs_idles: assert property (p_lock_needs_idles) else $error("lock without idle count");

	property p_lock_loss;
		link_up && err_hit && link_on |=> !link_up ##1 !link_up;
	endproperty
	a_lock_loss: assert property (p_lock_loss) else $error("link kept after error count");

	property p_remote_low;
		remote_rx_ok && rr_hit |=> !remote_rx_ok;
	endproperty
	a_remote_low: assert property (p_remote_low) else $error("remote status kept high");

	property p_sleep_gate;
		sleep_code_en |-> $past(s_r.sleep_en[`SE_EN_BIT]);
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("sleep codes enabled while bit clear");

	property p_force_ilv;
		s_r.ilv_cfg[`IC_FORCE_BIT] |=> tx_interleave;
	endproperty
	a_force_ilv: assert property (p_force_ilv) else $error("force interleave ignored");

	property p_detect_ilv;
		tx_interleave && !$past(s_r.ilv_cfg[`IC_FORCE_BIT]) |-> $past(s_r.ilv_cfg[`IC_EN_BIT])
			&& $past(s_r.ilv_cfg[`IC_DET_BIT]) && s_r.ilv_seen;
	endproperty
	a_detect_ilv: assert property (p_detect_ilv) else $error("interleave without detection");

	property p_jabber_time;
		$rose(jabber) |-> $past(s_r.us_cnt) == $past(s_r.jabber_timeout_config[`JC_TMO_MSB:`JC_TMO_LSB]);
	endproperty
	a_jabber_time: assert property (p_jabber_time) else $error("jabber at wrong time");

	property p_tm_count;
		$fell(tm1_valid) |-> tm_seen_r == 9'(({1'b0, s_r.tm_cfg[`TC_SYM_MSB:`TC_SYM_LSB], 1'b0} + 8'h02)
			* `TM_SYM_CYC);
	endproperty
	a_tm_count: assert property (p_tm_count) else $error("test mode symbol count wrong");

	property p_reserved_ro;
		s_r.pready && !apb_in.pwrite && sel_idx == `IDX_LINK_CTRL |-> apb_out.prdata[11:9] == 3'h0;
	endproperty
	a_reserved_ro: assert property (p_reserved_ro) else $error("reserved bits changed");

	c_link_up: cover property ($rose(link_up));
	c_lock_lost: cover property ($fell(link_up) && link_on);
	c_jabber: cover property ($rose(jabber));
	c_tm_done: cover property ($fell(tm1_valid));
endmodule

// >>> link_partner_model.sv
// Remote link partner: sends idle or error symbols, marks gaps and signals received interleave.
// Assumes the bench steers sym_mode, in_gap and ilv on rising edges of sys_clk.
`timescale 1ns/1ps
module link_partner_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [1:0] sym_mode,
	input wire logic in_gap,
	input wire logic ilv,
	output pcs_link_pkg::rx_sym_s rx_sym,
	output logic rx_ilv_seen
);
	import pcs_link_pkg::*;
	logic tog;

	// ==========================================
	// Symbol stream, flags toggle while no symbol is sent
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sym <= '0;
			rx_ilv_seen <= 1'b0;
			tog <= 1'b0;
		end else begin
			tog <= ~tog;
			rx_sym.valid <= (sym_mode != 2'd0);
			rx_sym.idle <= (sym_mode == 2'd1) | ((sym_mode == 2'd0) & tog);
			rx_sym.err <= (sym_mode == 2'd2) | ((sym_mode == 2'd0) & ~tog);
			rx_sym.in_ipg <= (sym_mode == 2'd0) ? tog : in_gap;
			rx_ilv_seen <= ilv;
		end
	end
endmodule

// >>> testbench.sv
// Self-checking bench for the PCS link control register bank over APB.
// Assumes pcs_link_pkg and link_partner_model are compiled first.
`timescale 1ns/1ps
`include "pcs_link_map.svh"
module testbench;
	import pcs_link_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	apb_in_s apb_in = '0;
	apb_out_s apb_out;
	rx_sym_s rx_sym;
	logic rx_ilv_seen;
	logic tx_active = 1'b0;
	logic tm1_start = 1'b0;
	logic link_up, training_en, remote_rx_ok, sleep_code_en, tx_interleave, jabber, tm1_valid, tm1_positive, irq;
	logic [1:0] sym_mode = 2'd0;
	logic in_gap = 1'b0;
	logic ilv = 1'b0;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [15:0] rd;
	logic err;
	logic [13:0] idx_tab [7] = '{`IDX_LINK_CTRL, `IDX_ERR_THR, `IDX_SLEEP_EN, `IDX_ILV_CFG, `IDX_SLEEP_TMR,
		`IDX_JABBER_TIMEOUT_CONFIG, `IDX_TM_CFG};
	logic [15:0] rst_tab [7] = '{`RST_LINK_CTRL, `RST_ERR_THR, `RST_SLEEP_EN, `RST_ILV_CFG, `RST_SLEEP_TMR,
		`RST_JABBER_TIMEOUT_CONFIG, `RST_TM_CFG};
	logic [15:0] wm_tab [7] = '{`WM_LINK_CTRL, `WM_ALL, `WM_ALL, `WM_ILV_CFG, `WM_ALL, `WM_JABBER_TIMEOUT_CONFIG, `WM_TM_CFG};

	always #10 sys_clk = ~sys_clk;

	pcs_link_control_regs pcs_link_control_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .apb_in(apb_in),
		.apb_out(apb_out), .rx_sym(rx_sym), .rx_ilv_seen(rx_ilv_seen), .tx_active(tx_active),
		.tm1_start(tm1_start), .link_up(link_up), .training_en(training_en), .remote_rx_ok(remote_rx_ok),
		.sleep_code_en(sleep_code_en), .tx_interleave(tx_interleave), .jabber(jabber), .tm1_valid(tm1_valid),
		.tm1_positive(tm1_positive), .irq(irq));

	link_partner_model link_partner_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .sym_mode(sym_mode),
		.in_gap(in_gap), .ilv(ilv), .rx_sym(rx_sym), .rx_ilv_seen(rx_ilv_seen));

	// ==========================================
	// Shared tasks
	task tally_and_finish;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Full APB transfer, ends one idle cycle after release
	task apb(input logic wr, input logic [13:0] idx, input logic [15:0] wd);
		apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {16'h0000, wd}};
		@(posedge sys_clk);
		apb_in.penable <= 1'b1;
		@(posedge sys_clk);
		while (apb_out.pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = apb_out.prdata[15:0];
		err = apb_out.pslverr;
		apb_in <= '0;
		@(posedge sys_clk);
	endtask

	// Extra edge lets outputs registered from the new value settle
	task wr(input logic [13:0] idx, input logic [15:0] wd);
		apb(1'b1, idx, wd);
		@(posedge sys_clk);
	endtask

	task rdc(input logic [13:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0000);
		chk(rd, exp);
	endtask

	// ==========================================
	// Scenarios
	task t_regs;
		chk(training_en, 1'b1);
		chk(sleep_code_en, 1'b0);
		chk(tx_interleave, 1'b0);
		for (int i = 0; i < 7; i++) begin
			rdc(idx_tab[i], rst_tab[i]);
			wr(idx_tab[i], 16'hffff);
			rdc(idx_tab[i], wm_tab[i] | (rst_tab[i] & ~wm_tab[i]));
			wr(idx_tab[i], rst_tab[i]);
		end
		apb(1'b1, 14'h0100, 16'h1234);
		chk(err, 1'b1);
		apb(1'b0, 14'h0100, 16'h0000);
		chk(rd, 16'h0000);
	endtask

	task t_link;
		int n;
		wr(`IDX_LINK_CTRL, 16'h1004);
		wr(`IDX_ERR_THR, 16'h0402);
		wr(`IDX_IRQ_MASK, 16'h001f);
		sym_mode <= 2'd1;
		cyc(3);
		sym_mode <= 2'd0;
		cyc(6);
		chk(link_up, 1'b0);
		sym_mode <= 2'd1;
		n = 0;
		while (link_up !== 1'b1 && n < 30) begin
			n++;
			@(posedge sys_clk);
		end
		sym_mode <= 2'd0;
		chk(link_up, 1'b1);
		cyc(2);
		chk(remote_rx_ok, 1'b1);
		chk(irq, 1'b1);
		wr(`IDX_LINK_CTRL, 16'h3004);
		sym_mode <= 2'd2;
		in_gap <= 1'b1;
		cyc(8);
		sym_mode <= 2'd0;
		in_gap <= 1'b0;
		cyc(4);
		chk(link_up, 1'b1);
		chk(remote_rx_ok, 1'b1);
		wr(`IDX_LINK_CTRL, 16'h1004);
		sym_mode <= 2'd2;
		cyc(2);
		sym_mode <= 2'd0;
		cyc(4);
		chk(remote_rx_ok, 1'b0);
		chk(link_up, 1'b1);
		sym_mode <= 2'd2;
		cyc(2);
		sym_mode <= 2'd0;
		cyc(4);
		chk(link_up, 1'b0);
	endtask

	task t_link_off;
		wr(`IDX_LINK_CTRL, 16'h0004);
		cyc(2);
		chk(training_en, 1'b0);
		sym_mode <= 2'd1;
		cyc(12);
		sym_mode <= 2'd0;
		cyc(3);
		chk(link_up, 1'b0);
		wr(`IDX_LINK_CTRL, 16'h1004);
		chk(training_en, 1'b1);
	endtask

	task t_sleep_ilv;
		wr(`IDX_SLEEP_EN, 16'h0a01);
		chk(sleep_code_en, 1'b1);
		wr(`IDX_SLEEP_EN, 16'h0a00);
		chk(sleep_code_en, 1'b0);
		wr(`IDX_ILV_CFG, 16'h0004);
		chk(tx_interleave, 1'b1);
		wr(`IDX_ILV_CFG, 16'h0003);
		chk(tx_interleave, 1'b0);
		ilv <= 1'b1;
		cyc(4);
		chk(tx_interleave, 1'b1);
		wr(`IDX_ILV_CFG, 16'h0002);
		chk(tx_interleave, 1'b0);
		ilv <= 1'b0;
	endtask

	task t_jabber;
		int n;
		wr(`IDX_JABBER_TIMEOUT_CONFIG, 16'h0002);
		wr(`IDX_IRQ_MASK, 16'h0008);
		wr(`IDX_IRQ_STAT, 16'h001f);
		chk(irq, 1'b0);
		tx_active <= 1'b1;
		n = 0;
		while (jabber !== 1'b1 && n < 300) begin
			n++;
			@(posedge sys_clk);
		end
		chk(n >= 95 && n <= 110, 1'b1);
		cyc(2);
		chk(irq, 1'b1);
		rdc(`IDX_IRQ_STAT, 16'h0008);
		wr(`IDX_IRQ_MASK, 16'h0000);
		chk(irq, 1'b0);
		tx_active <= 1'b0;
		cyc(3);
		chk(jabber, 1'b0);
		wr(`IDX_IRQ_STAT, 16'h0008);
		wr(`IDX_IRQ_MASK, 16'h0008);
		chk(irq, 1'b0);
	endtask

	task t_test_mode;
		int cnt;
		int bad;
		cnt = 0;
		bad = 0;
		wr(`IDX_TM_CFG, 16'h0030);
		tm1_start <= 1'b1;
		@(posedge sys_clk);
		tm1_start <= 1'b0;
		repeat (40) begin
			@(posedge sys_clk);
			if (tm1_valid === 1'b1) begin
				if (tm1_positive !== ~cnt[0])
					bad++;
				cnt++;
			end
		end
		chk(cnt, 8);
		chk(bad, 0);
	endtask

	// ==========================================
	// Main sequence and hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_regs();
		t_link();
		t_link_off();
		t_sleep_ilv();
		t_jabber();
		t_test_mode();
		tally_and_finish();
	end
endmodule
